/* File: dv/dps_motion_model.sv */
`timescale 1ns/1ps
// ****************************************
// motion engine stand-in
// ****************************************
module dps_motion_model #(
  parameter int STEP = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // commands from the decoder
  input wire logic home_req,
  input wire logic move_go,
  input wire logic stop_req,
  input wire logic [31:0] target_pos,
  // engine state
  output logic [31:0] shaft_pos,
  output logic motion_busy,
  output logic motion_dir_pos,
  output logic home_done
);
  logic [31:0] goal_ff;
  logic [3:0] hcnt_ff;
  logic signed [31:0] diff;
  logic [31:0] step_pos;
  assign diff = $signed(goal_ff) - $signed(shaft_pos);
  assign step_pos = motion_dir_pos ? shaft_pos + STEP : shaft_pos - STEP;
  // homing takes a dozen cycles so early select changes land inside it
  always_ff @(posedge clk) begin
    home_done <= 1'b0;
    if (rst) begin
      shaft_pos <= 32'h0000_0100;
      goal_ff <= 32'h0000_0000;
      hcnt_ff <= 4'h0;
      motion_busy <= 1'b0;
      motion_dir_pos <= 1'b0;
    end else if (move_go) begin
      goal_ff <= target_pos;
      motion_busy <= 1'b1;
      motion_dir_pos <= $signed(target_pos) > $signed(shaft_pos);
    end else if (home_req) begin
      hcnt_ff <= 4'hc;
    end else if (hcnt_ff != 4'h0) begin
      hcnt_ff <= hcnt_ff - 4'h1;
      if (hcnt_ff == 4'h1) begin
        home_done <= 1'b1;
        shaft_pos <= 32'h0000_0000;
      end
    end else if (motion_busy) begin
      // a stop request still coasts one step before standing
      if (stop_req || diff <= STEP && diff >= -STEP) begin
        motion_busy <= 1'b0;
      end
      shaft_pos <= (!stop_req && diff <= STEP && diff >= -STEP) ? goal_ff : step_pos;
    end
  end
endmodule : dps_motion_model

/* File: dv/test_dps_decoder.sv */
`timescale 1ns/1ps
`include "dps_consts.svh"
module test_dps_decoder;
  // ****************************************
  // signals
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, shaft_pos, target_pos, speed_lim, accel_lim, q;
  logic avs_waitrequest, motion_busy, motion_dir_pos, home_done, motor_energize;
  logic home_req, move_go, stop_req, shutdown, irq;
  logic enable_in = 1'b0;
  logic sel_a_in = 1'b0;
  logic sel_b_in = 1'b0;
  logic main_bus_power_on = 1'b1;
  logic logic_backup_power_state = 1'b1;
  logic [5:0] watch;
  logic [31:0] tgt [4] = '{32'h0000_03e8, 32'h0000_07d0, 32'h0000_01f4, 32'h0000_0fa0};
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  assign watch = {irq, shutdown, stop_req, motor_energize, home_req, move_go};

  dps_decoder #(.DISABLE_CYC(20)) u_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .enable_in(enable_in),
    .sel_a_in(sel_a_in), .sel_b_in(sel_b_in), .shaft_pos(shaft_pos),
    .motion_busy(motion_busy), .motion_dir_pos(motion_dir_pos), .home_done(home_done),
    .main_bus_power_on(main_bus_power_on),
    .logic_backup_power_state(logic_backup_power_state), .motor_energize(motor_energize),
    .home_req(home_req), .move_go(move_go), .stop_req(stop_req), .target_pos(target_pos),
    .speed_lim(speed_lim), .accel_lim(accel_lim), .shutdown(shutdown), .irq(irq));
  dps_motion_model u_motion (.clk(clk), .rst(rst), .home_req(home_req), .move_go(move_go),
    .stop_req(stop_req), .target_pos(target_pos), .shaft_pos(shaft_pos),
    .motion_busy(motion_busy), .motion_dir_pos(motion_dir_pos), .home_done(home_done));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge clk);
    // the wait ends once avs_waitrequest drops low
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, exp, q);
  endtask : rdchk
  task automatic pins(input logic e, input logic a, input logic b);
    @(posedge clk);
    enable_in <= e;
    sel_a_in <= a;
    sel_b_in <= b;
  endtask : pins
  // i picks a bit of watch; v is the level looked for within n edges
  task automatic see(input string what, input int i, input logic v, input int n);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < n && !hit; k++) begin
      @(posedge clk);
      hit = (watch[i] === v);
    end
    chk(what, 32'h0000_0001, {31'h0, hit});
  endtask : see
  task automatic quiet(input string what, input int i, input int n);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      hit = hit | (watch[i] !== 1'b0);
    end
    chk(what, 32'h0000_0000, {31'h0, hit});
  endtask : quiet
  task automatic go(input string what, input logic [31:0] exp, input int n);
    see(what, 0, 1'b1, n);
    chk(what, exp, target_pos);
  endtask : go
  task automatic settle;
    // let the engine take the launch before asking whether it is idle
    @(posedge clk);
    for (int k = 0; k < 2000 && motion_busy !== 1'b0; k++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask : settle
  task automatic pulse_b(input int n, input logic a);
    for (int k = 0; k < n; k++) begin
      pins(1'b1, a, 1'b1);
      repeat (4) @(posedge clk);
      pins(1'b1, a, 1'b0);
      repeat (4) @(posedge clk);
    end
  endtask : pulse_b

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    chk("waitrequest idle", 32'h0000_0001, {31'h0, avs_waitrequest});
    chk("energize", 32'h0000_0000, {31'h0, motor_energize});
    rdchk("ctrl", `DPS_OFS_CTRL, 32'h0000_0000);
    rdchk("accel", `DPS_OFS_ACCEL, 32'h0000_0000);
    bus(1'b1, `DPS_OFS_STATUS, 32'hffff_ffff);
    rdchk("status", `DPS_OFS_STATUS, 32'h0000_0000);
    bus(1'b1, 8'h30, 32'h5a5a_5a5a);
    rdchk("unmapped", 8'h30, 32'h0000_0000);
    bus(1'b1, `DPS_OFS_SPEED, 32'h0000_1234);
    bus(1'b1, `DPS_OFS_ACCEL, 32'h0000_0056);
    @(posedge clk);
    chk("speed_lim", 32'h0000_1234, speed_lim);
    chk("accel_lim", 32'h0000_0056, accel_lim);
    for (int i = 0; i < 4; i++) bus(1'b1, 8'h40 + 8'(4 * i), tgt[i]);
    rdchk("target 2", 8'h48, tgt[2]);
  endtask : t_regs
  task automatic t_four;
    logic [1:0] seq [4] = '{2'd3, 2'd2, 2'd1, 2'd0};
    pins(1'b1, 1'b0, 1'b0);
    see("home_req", 1, 1'b1, 8);
    pins(1'b1, 1'b1, 1'b0);
    quiet("early move", 0, 25);
    chk("energize", 32'h0000_0001, {31'h0, motor_energize});
    bus(1'b0, `DPS_OFS_STATUS, 32'h0000_0000);
    chk("homed", 32'h0000_0001, {31'h0, q[3]});
    foreach (seq[i]) begin
      pins(1'b1, seq[i][0], seq[i][1]);
      go("four target", tgt[seq[i]], 8);
      settle();
    end
    rdchk("irq stat", `DPS_OFS_IRQ_STAT, 32'h0000_0003);
  endtask : t_four
  task automatic t_chase;
    pins(1'b1, 1'b1, 1'b0);
    go("first leg", tgt[1], 8);
    repeat (10) @(posedge clk);
    pins(1'b1, 1'b1, 1'b1);
    go("same way", tgt[3], 8);
    chk("no stop", 32'h0000_0000, {31'h0, stop_req});
    repeat (10) @(posedge clk);
    pins(1'b1, 1'b0, 1'b1);
    see("reverse stop", 3, 1'b1, 8);
    go("reverse", tgt[2], 20);
    settle();
  endtask : t_chase
  task automatic t_irq;
    bus(1'b1, `DPS_OFS_IRQ_MASK, 32'h0000_0001);
    see("irq on", 5, 1'b1, 4);
    bus(1'b1, `DPS_OFS_IRQ_MASK, 32'h0000_0000);
    see("irq masked", 5, 1'b0, 4);
    bus(1'b1, `DPS_OFS_IRQ_MASK, 32'h0000_0001);
    bus(1'b1, `DPS_OFS_IRQ_STAT, 32'h0000_0001);
    see("irq cleared", 5, 1'b0, 4);
    rdchk("irq stat w1c", `DPS_OFS_IRQ_STAT, 32'h0000_0002);
  endtask : t_irq
  task automatic t_disable;
    pins(1'b1, 1'b1, 1'b0);
    go("pre disable", tgt[1], 8);
    pins(1'b0, 1'b1, 1'b0);
    see("disable stop", 3, 1'b1, 6);
    see("disabled", 2, 1'b0, 28);
    settle();
  endtask : t_disable
  task automatic t_teach;
    @(posedge clk);
    main_bus_power_on <= 1'b0;
    pins(1'b0, 1'b1, 1'b1);
    repeat (4) @(posedge clk);
    pins(1'b1, 1'b1, 1'b1);
    quiet("teach energize", 2, 10);
    tgt[3] = shaft_pos;
    rdchk("taught", 8'h4c, tgt[3]);
    pins(1'b0, 1'b0, 1'b0);
    main_bus_power_on <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : t_teach
  task automatic t_sixteen;
    bus(1'b1, `DPS_OFS_CTRL, 32'h0000_0003);
    pins(1'b1, 1'b0, 1'b0);
    see("home16", 1, 1'b1, 8);
    repeat (20) @(posedge clk);
    pulse_b(3, 1'b0);
    pins(1'b1, 1'b1, 1'b0);
    go("index 3", tgt[2], 8);
    pulse_b(2, 1'b1);
    quiet("pulses held", 0, 10);
    bus(1'b0, `DPS_OFS_STATUS, 32'h0000_0000);
    chk("count held", 32'h0000_0003, {27'h0, q[8:4]});
    pins(1'b1, 1'b0, 1'b0);
    repeat (6) @(posedge clk);
    bus(1'b0, `DPS_OFS_STATUS, 32'h0000_0000);
    chk("count cleared", 32'h0000_0000, {27'h0, q[8:4]});
    settle();
    pulse_b(2, 1'b0);
    pins(1'b1, 1'b1, 1'b0);
    go("index 2", tgt[1], 8);
    pins(1'b1, 1'b0, 1'b0);
    pulse_b(4, 1'b0);
    pins(1'b1, 1'b1, 1'b0);
    go("supersede", tgt[3], 8);
    settle();
    pins(1'b1, 1'b0, 1'b0);
    pulse_b(17, 1'b0);
    pins(1'b1, 1'b1, 1'b0);
    see("bad index", 4, 1'b1, 8);
    pins(1'b0, 1'b0, 1'b0);
    see("shutdown cleared", 4, 1'b0, 40);
    pins(1'b1, 1'b0, 1'b0);
    see("home again", 1, 1'b1, 8);
  endtask : t_sixteen

  // ****************************************
  // run control
  // ****************************************
  task automatic results;
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_four();
    t_chase();
    t_irq();
    t_disable();
    t_teach();
    t_sixteen();
    results();
  end
endmodule : test_dps_decoder

/* File: rtl/dps_consts.svh */
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define DPS_ADDR_W 8
`define DPS_OFS_CTRL 8'h00
`define DPS_OFS_STATUS 8'h04
`define DPS_OFS_IRQ_STAT 8'h08
`define DPS_OFS_IRQ_MASK 8'h0C
`define DPS_OFS_SPEED 8'h10
`define DPS_OFS_ACCEL 8'h14
`define DPS_TGT_BASE_HI 2'b01
`define DPS_TGT_DEPTH 16

// ****************************************
// field positions and reset values
// ****************************************
`define DPS_CTRL_MODE16 0
`define DPS_CTRL_HOME_EVERY 1
`define DPS_EV_W 4
`define DPS_EV_MOVE 0
`define DPS_EV_HOMED 1
`define DPS_EV_BADIDX 2
`define DPS_EV_TAUGHT 3
`define DPS_CTRL_RST 2'h0
`define DPS_LIMIT_RST 32'h0000_0000
`define DPS_CNT_W 5
`define DPS_CNT_MAX 5'h10
`define DPS_CNT_OVER 5'h11

// ****************************************
// timing
// ****************************************
`define DPS_CLK_HZ 10000000
`define DPS_DISABLE_TIME_MS 10
`define DPS_DIS_CNT_W 20

`endif

/* File: rtl/dps_decoder.sv */
`timescale 1ns/1ps
`include "dps_consts.svh"
// What this block does
// - enable high energizes the motor, low disables; the device follows it.
// - four-position mode homes to a hard stop before any move.
// - homing runs on first enable or on every enable, per configuration.
// - A/B levels pick target 1..4: LL=1, A-only=2, B-only=3, both=4.
// - any select change after homing picks the target and launches the move.
// - every move uses the configured speed and acceleration limits.
// - a new target in the current direction is chased without stopping.
// - a new target in the opposite direction: stop first, then move.
// - with bus power off and backup on, enable rise stores shaft location.
// - disable completes within the disable time after enable falls.
// - sixteen-position mode needs homing before indexed moves.
// - complete pulses on B are counted to build the target index.
// - A rising launches the move to the counted index.
// - while A is high, B pulses are ignored and the position held.
// - A falling clears the counted index.
// - A rising after more than sixteen pulses shuts down until enable toggles.
// - a new indexed command replaces the move in progress.
module dps_decoder #(
  parameter int DISABLE_CYC = `DPS_DISABLE_TIME_MS * (`DPS_CLK_HZ / 1000)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // controller pins
  input wire logic enable_in,
  input wire logic sel_a_in,
  input wire logic sel_b_in,
  // motion engine side
  input wire logic [31:0] shaft_pos,
  input wire logic motion_busy,
  input wire logic motion_dir_pos,
  input wire logic home_done,
  input wire logic main_bus_power_on,
  input wire logic logic_backup_power_state,
  output logic motor_energize,
  output logic home_req,
  output logic move_go,
  output logic stop_req,
  output logic [31:0] target_pos,
  output logic [31:0] speed_lim,
  output logic [31:0] accel_lim,
  output logic shutdown,
  output logic irq
);

  // ****************************************
  // input synchronizers
  // ****************************************
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  logic [2:0] pin_s3_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
      pin_s3_ff <= 3'h0;
    end else begin
      pin_s1_ff <= {sel_b_in, sel_a_in, enable_in};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  wire en_s = pin_s2_ff[0];
  wire a_s = pin_s2_ff[1];
  wire b_s = pin_s2_ff[2];
  wire en_rise = en_s & ~pin_s3_ff[0];
  wire a_rise = a_s & ~pin_s3_ff[1];
  wire a_fall = ~a_s & pin_s3_ff[1];
  wire b_fall = ~b_s & pin_s3_ff[2];
  wire sel_chg = (pin_s2_ff[2:1] != pin_s3_ff[2:1]);

  function automatic logic [3:0] sel_idx(input logic a, input logic b);
    sel_idx = {2'b00, b, a};
  endfunction : sel_idx

  // ****************************************
  // registers
  // ****************************************
  dps_pkg::dps_state_e state_ff;
  dps_pkg::dps_state_e nxt_state;
  logic [1:0] ctrl_ff;
  logic [`DPS_EV_W-1:0] stat_ff;
  logic [`DPS_EV_W-1:0] mask_ff;
  logic [31:0] tgt_mem_ff [`DPS_TGT_DEPTH];
  logic [`DPS_CNT_W-1:0] cnt_ff;
  logic [`DPS_CNT_W-1:0] nxt_cnt;
  logic [`DPS_DIS_CNT_W-1:0] dis_cnt_ff;
  logic [`DPS_DIS_CNT_W-1:0] nxt_dis_cnt;
  logic homed_ff;
  logic nxt_homed;
  logic [31:0] pend_ff;
  logic [31:0] nxt_pend;
  logic [31:0] nxt_target;
  logic nxt_go;
  logic nxt_stop;
  logic nxt_home_req;
  logic teach_we;
  logic [`DPS_EV_W-1:0] ev;

  wire mode16 = ctrl_ff[`DPS_CTRL_MODE16];
  wire home_every = ctrl_ff[`DPS_CTRL_HOME_EVERY];

  // ****************************************
  // bus decode
  // ****************************************
  wire bus_req = avs_read | avs_write;
  wire bus_done = bus_req & ~avs_waitrequest;
  wire bus_wr = avs_write & bus_done;
  wire is_tgt = (avs_address[7:6] == `DPS_TGT_BASE_HI);
  wire [3:0] bus_tidx = avs_address[5:2];
  wire wr_ctrl = bus_wr & (avs_address == `DPS_OFS_CTRL);
  wire wr_stat = bus_wr & (avs_address == `DPS_OFS_IRQ_STAT);
  wire wr_mask = bus_wr & (avs_address == `DPS_OFS_IRQ_MASK);
  wire wr_speed = bus_wr & (avs_address == `DPS_OFS_SPEED);
  wire wr_accel = bus_wr & (avs_address == `DPS_OFS_ACCEL);
  wire wr_tgt = bus_wr & is_tgt & (avs_address[1:0] == 2'b00);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_tgt) begin
      rd_mux = tgt_mem_ff[bus_tidx];
    end else begin
      case (avs_address)
        `DPS_OFS_CTRL: rd_mux = {30'h0000_0000, ctrl_ff};
        `DPS_OFS_STATUS: rd_mux = {19'h0_0000, sel_idx(a_s, b_s), cnt_ff, homed_ff,
                                   state_ff};
        `DPS_OFS_IRQ_STAT: rd_mux = {28'h000_0000, stat_ff};
        `DPS_OFS_IRQ_MASK: rd_mux = {28'h000_0000, mask_ff};
        `DPS_OFS_SPEED: rd_mux = speed_lim;
        `DPS_OFS_ACCEL: rd_mux = accel_lim;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // one wait cycle: data latched while waitrequest is high, taken on the next edge
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (bus_req & avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // ****************************************
  // move candidate selection
  // ****************************************
  wire teach_ok = ~main_bus_power_on & logic_backup_power_state;
  wire [`DPS_CNT_W-1:0] cnt_m1 = cnt_ff - 5'h01;
  wire [3:0] cand_idx = mode16 ? cnt_m1[3:0] : sel_idx(a_s, b_s);
  wire [31:0] cand_tgt = tgt_mem_ff[cand_idx];
  wire cnt_ok = (cnt_ff != 5'h00) & (cnt_ff <= `DPS_CNT_MAX);
  wire launch = mode16 ? (a_rise & cnt_ok) : sel_chg;
  wire bad_idx = mode16 & a_rise & (cnt_ff > `DPS_CNT_MAX);
  wire cand_fwd = $signed(cand_tgt) > $signed(shaft_pos);
  wire need_stop = ~mode16 & motion_busy & (cand_fwd != motion_dir_pos);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_dis_cnt = dis_cnt_ff;
    nxt_homed = homed_ff;
    nxt_pend = pend_ff;
    nxt_target = target_pos;
    nxt_go = 1'b0;
    nxt_stop = 1'b0;
    nxt_home_req = 1'b0;
    teach_we = 1'b0;
    ev = 4'h0;
    case (state_ff)
      dps_pkg::ST_OFF: begin
        // act on the enable level, so a rise during disabling is not lost
        if (en_s) begin
          nxt_cnt = 5'h00;
          if (teach_ok) begin
            teach_we = 1'b1;
            ev[`DPS_EV_TAUGHT] = 1'b1;
            nxt_state = dps_pkg::ST_TEACH;
          end else if (~homed_ff | home_every) begin
            nxt_homed = 1'b0;
            nxt_home_req = 1'b1;
            nxt_state = dps_pkg::ST_HOME;
          end else begin
            nxt_state = dps_pkg::ST_RUN;
          end
        end
      end
      dps_pkg::ST_HOME: begin
        if (~en_s) begin
          nxt_state = dps_pkg::ST_DIS;
          nxt_dis_cnt = '0;
          nxt_stop = 1'b1;
        end else if (home_done) begin
          nxt_homed = 1'b1;
          ev[`DPS_EV_HOMED] = 1'b1;
          nxt_cnt = 5'h00;
          nxt_state = dps_pkg::ST_RUN;
        end
      end
      dps_pkg::ST_RUN: begin
        if (~en_s) begin
          nxt_state = dps_pkg::ST_DIS;
          nxt_dis_cnt = '0;
          nxt_stop = 1'b1;
        end else if (bad_idx) begin
          ev[`DPS_EV_BADIDX] = 1'b1;
          nxt_state = dps_pkg::ST_SHUT;
        end else begin
          if (launch & need_stop) begin
            nxt_pend = cand_tgt;
            nxt_stop = 1'b1;
            nxt_state = dps_pkg::ST_STOP;
          end else if (launch) begin
            nxt_go = 1'b1;
            nxt_target = cand_tgt;
            ev[`DPS_EV_MOVE] = 1'b1;
          end
          if (mode16 & a_fall) begin
            nxt_cnt = 5'h00;
          end else if (mode16 & b_fall & ~a_s & (cnt_ff != `DPS_CNT_OVER)) begin
            nxt_cnt = cnt_ff + 5'h01;
          end
        end
      end
      dps_pkg::ST_STOP: begin
        if (~en_s) begin
          nxt_state = dps_pkg::ST_DIS;
          nxt_dis_cnt = '0;
          nxt_stop = 1'b1;
        end else begin
          // latest selection wins while ramping down
          if (sel_chg) begin
            nxt_pend = cand_tgt;
          end
          if (~motion_busy) begin
            nxt_go = 1'b1;
            nxt_target = sel_chg ? cand_tgt : pend_ff;
            ev[`DPS_EV_MOVE] = 1'b1;
            nxt_state = dps_pkg::ST_RUN;
          end else begin
            nxt_stop = 1'b1;
          end
        end
      end
      dps_pkg::ST_DIS: begin
        nxt_dis_cnt = dis_cnt_ff + 20'h0_0001;
        nxt_stop = 1'b1;
        if (~motion_busy | (dis_cnt_ff >= 20'(DISABLE_CYC - 1))) begin
          nxt_stop = 1'b0;
          nxt_state = dps_pkg::ST_OFF;
        end
      end
      dps_pkg::ST_SHUT: begin
        // only an enable toggle clears it
        if (~en_s) begin
          nxt_state = dps_pkg::ST_OFF;
        end
      end
      dps_pkg::ST_TEACH: begin
        if (~en_s) begin
          nxt_state = dps_pkg::ST_OFF;
        end
      end
      default: begin
        nxt_state = dps_pkg::ST_OFF;
      end
    endcase
  end

  wire nxt_energize = (nxt_state == dps_pkg::ST_HOME) | (nxt_state == dps_pkg::ST_RUN) |
                      (nxt_state == dps_pkg::ST_STOP) | (nxt_state == dps_pkg::ST_DIS);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= dps_pkg::ST_OFF;
      cnt_ff <= 5'h00;
      dis_cnt_ff <= '0;
      homed_ff <= 1'b0;
      pend_ff <= 32'h0000_0000;
      target_pos <= 32'h0000_0000;
      move_go <= 1'b0;
      stop_req <= 1'b0;
      home_req <= 1'b0;
      motor_energize <= 1'b0;
      shutdown <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      dis_cnt_ff <= nxt_dis_cnt;
      homed_ff <= nxt_homed;
      pend_ff <= nxt_pend;
      target_pos <= nxt_target;
      move_go <= nxt_go;
      stop_req <= nxt_stop;
      home_req <= nxt_home_req;
      motor_energize <= nxt_energize;
      shutdown <= (nxt_state == dps_pkg::ST_SHUT);
    end
  end

  // ****************************************
  // configuration, targets, interrupts
  // ****************************************
  // control, irq mask and the limits held for the motion engine
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= `DPS_CTRL_RST;
      speed_lim <= `DPS_LIMIT_RST;
      accel_lim <= `DPS_LIMIT_RST;
      mask_ff <= 4'h0;
    end else begin
      if (wr_ctrl) ctrl_ff <= avs_writedata[1:0];
      if (wr_speed) speed_lim <= avs_writedata;
      if (wr_accel) accel_lim <= avs_writedata;
      if (wr_mask) mask_ff <= avs_writedata[3:0];
    end
  end

  // teach wins over a bus write in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < `DPS_TGT_DEPTH; i++) begin
        tgt_mem_ff[i] <= 32'h0000_0000;
      end
    end else if (teach_we) begin
      tgt_mem_ff[cand_idx] <= shaft_pos;
    end else if (wr_tgt) begin
      tgt_mem_ff[bus_tidx] <= avs_writedata;
    end
  end

  // a new event beats a write-one-to-clear in the same cycle
  wire [3:0] nxt_stat = (stat_ff & ~(wr_stat ? avs_writedata[3:0] : 4'h0)) | ev;
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_ff <= 4'h0;
      irq <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq <= |(nxt_stat & (wr_mask ? avs_writedata[3:0] : mask_ff));
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking dps_cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_ENABLE_RISE: assert property (
    (state_ff == dps_pkg::ST_OFF) && en_rise && !teach_ok |=> motor_energize)
    else $error("enable rise did not energize");
  AST_ENABLE_FALL: assert property (
    (state_ff == dps_pkg::ST_RUN) && !en_s |=> (state_ff == dps_pkg::ST_DIS) && stop_req)
    else $error("enable fall did not start disable");
  AST_GO_HOMED: assert property (
    move_go |-> homed_ff && motor_energize)
    else $error("move launched without homing");
  AST_HOME_EVERY: assert property (
    (state_ff == dps_pkg::ST_OFF) && en_rise && !teach_ok && home_every
    |=> home_req ##1 !home_req)
    else $error("home-every policy ignored");
  AST_SEL_LAUNCH: assert property (
    (state_ff == dps_pkg::ST_RUN) && en_s && !mode16 && sel_chg && !need_stop
    |=> move_go && (target_pos == $past(cand_tgt)))
    else $error("select change did not launch");
  AST_REVERSE_STOP: assert property (
    (state_ff == dps_pkg::ST_RUN) && en_s && !mode16 && sel_chg && need_stop
    |=> stop_req && !move_go)
    else $error("reversal did not stop first");
  AST_TEACH: assert property (
    (state_ff == dps_pkg::ST_OFF) && en_rise && teach_ok
    |=> (state_ff == dps_pkg::ST_TEACH) && !motor_energize)
    else $error("teach entry wrong");
  AST_DIS_BOUND: assert property (
    (state_ff == dps_pkg::ST_DIS) |-> (dis_cnt_ff < 20'(DISABLE_CYC)))
    else $error("disable exceeded bound");
  AST_A_HOLD: assert property (
    (state_ff == dps_pkg::ST_RUN) && en_s && mode16 && a_s && b_fall
    |=> cnt_ff == $past(cnt_ff))
    else $error("pulse counted while A high");
  AST_A_CLEAR: assert property (
    (state_ff == dps_pkg::ST_RUN) && en_s && mode16 && a_fall |=> cnt_ff == 5'h00)
    else $error("index not cleared");
  AST_BAD_IDX: assert property (
    (state_ff == dps_pkg::ST_RUN) && en_s && bad_idx |=> shutdown && !motor_energize)
    else $error("invalid index not shut down");

  COV_FOUR_MOVE: cover property (!mode16 && move_go);
  COV_REVERSE: cover property (stop_req ##[1:50] move_go);
  COV_SIXTEEN_MOVE: cover property (mode16 && move_go);
  COV_SHUTDOWN: cover property ($rose(shutdown));

endmodule : dps_decoder

/* File: rtl/dps_pkg.sv */
package dps_pkg;
  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_HOME  = 3'b001,
    ST_RUN   = 3'b010,
    ST_STOP  = 3'b011,
    ST_DIS   = 3'b100,
    ST_SHUT  = 3'b101,
    ST_TEACH = 3'b110
  } dps_state_e;
endpackage : dps_pkg
